/* rtl/csierr_defs.vh */
// Constants for the camera link error status and mask bank.
// Assumes inclusion by bare name from the rtl folder.
`ifndef CSIERR_DEFS_VH
`define CSIERR_DEFS_VH

// Register byte offsets on the plain register port
`define CSIERR_ADDR_W          8
`define CSIERR_OFF_ERR1        8'h00
`define CSIERR_OFF_ERR2        8'h04
`define CSIERR_OFF_MASK1       8'h08
`define CSIERR_OFF_MASK2       8'h0C
`define CSIERR_OFF_IDSEL1      8'h10
`define CSIERR_OFF_IDSEL2      8'h14
`define CSIERR_OFF_CLR1        8'h18
`define CSIERR_OFF_CLR2        8'h1C
`define CSIERR_OFF_IEN1        8'h20
`define CSIERR_OFF_IEN2        8'h24

// Implemented widths of the two error layouts
`define CSIERR_ERR1_W          29
`define CSIERR_ERR2_W          24

// Field positions, first error layout
`define CSIERR_E1_ECC_DBL      28
`define CSIERR_E1_CKSUM_LSB    24
`define CSIERR_E1_LORD_LSB     20
`define CSIERR_E1_LPAIR_LSB    16
`define CSIERR_E1_FCRC_LSB     12
`define CSIERR_E1_FORD_LSB     8
`define CSIERR_E1_FPAIR_LSB    4
`define CSIERR_E1_SOTNS_LSB    0

// Field positions, second error layout
`define CSIERR_E2_LORD_LSB     20
`define CSIERR_E2_LPAIR_LSB    16
`define CSIERR_E2_UNKT_LSB     12
`define CSIERR_E2_HFIX_LSB     8
`define CSIERR_E2_SOTS_LSB     4
`define CSIERR_E2_ESC_LSB      0

// Identifier selection field layout within each byte
`define CSIERR_ID_VC_MSB       7
`define CSIERR_ID_VC_LSB       6
`define CSIERR_ID_DT_MSB       5
`define CSIERR_ID_DT_LSB       0

// Reset values
`define CSIERR_FLAGS_RST       32'h00000000
`define CSIERR_MASK_RST        32'h00000000
`define CSIERR_IDSEL_RST       32'h00000000
`define CSIERR_IEN_RST         32'h00000000
`define CSIERR_RDATA_RST       32'h00000000

`endif

/* rtl/csierr_flags.v */
// Bank of sticky error flags, set by hardware pulses, cleared by software.
// Assumes set and clear come from logic on the same clock.
`default_nettype none
`include "csierr_defs.vh"

module csierr_flags #(
    parameter W = 24
) (
    input  wire         clk_sys_i,  // System clock
    input  wire         nrst_i,     // Synchronous reset, active low
    input  wire [W-1:0] set_i,      // Event pulses, one per flag
    input  wire [W-1:0] clr_i,      // Clear pulses, one per flag
    output wire [W-1:0] flags_o     // Sticky flag state
);

    localparam [31:0] FLAGS_RST = `CSIERR_FLAGS_RST;

    reg  [W-1:0] flags_q;
    wire [W-1:0] flags_d;

    // Set beats clear so an event in the clearing cycle survives
    assign flags_d = set_i | (flags_q & ~clr_i);

    always @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            flags_q <= FLAGS_RST[W-1:0];
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;

endmodule
`default_nettype wire

/* rtl/csierr_top.v */
// Error status and mask registers of a camera serial link receiver.
// Assumes all event pulses come from front-end logic on clk_sys_i,
// one cycle long, and a single-cycle register strobe master.
`default_nettype none
`include "csierr_defs.vh"

// Function
// - Second error bits 23..20 flag line order faults, identifiers 7..4.
// - Second error bits 19..16 flag line start/end pairing faults, identifiers 7..4.
// - Second error bits 15..12 flag unknown data type, channels 3..0.
// - Second error bits 11..8 flag ECC-corrected header, channels 3..0.
// - Second error bits 7..4 flag recoverable start-of-transmission error, lanes 3..0.
// - Second error bits 3..0 flag escape entry error, lanes 3..0; 31..24 unused.
// - All second error flags read zero after reset.
// - First mask has bits 28..0 matching first error; upper unused; resets zero.
// - Second mask has bits 23..0 matching second error; upper unused; resets zero.
// - First error bit 28 double ECC error, bits 27..24 checksum per channel.
// - First error bits 15..12 frame CRC, 11..8 frame order, 7..4 frame pairing.
// - First error 23..16 line faults identifiers 3..0, 3..0 unsynced start errors.
// - Checked identifiers are programmed channel/type pairs; 4..7 in second select.
module csierr_top #(
    parameter AW = `CSIERR_ADDR_W
) (
    input  wire          clk_sys_i,          // System clock, 100 MHz
    input  wire          nrst_i,             // Synchronous reset, active low
    input  wire [AW-1:0] reg_addr_i,         // Register byte address
    input  wire [31:0]   reg_wdata_i,        // Register write data
    input  wire          reg_wr_i,           // Write strobe, one cycle
    input  wire          reg_rd_i,           // Read strobe, one cycle
    output wire [31:0]   reg_rdata_o,        // Read data, cycle after strobe
    input  wire          ecc_double_i,       // Unrecoverable header ECC pulse
    input  wire [3:0]    checksum_fault_i,   // Payload checksum fault per channel
    input  wire [3:0]    frame_crc_fault_i,  // Frame had CRC error, per channel
    input  wire [3:0]    frame_order_fault_i, // Frame sequence fault, per channel
    input  wire [3:0]    frame_pair_fault_i, // Frame start/end mismatch, per channel
    input  wire [3:0]    sot_nosync_i,       // Start error without sync, per lane
    input  wire [3:0]    sot_sync_i,         // Start error with sync, per lane
    input  wire [3:0]    esc_entry_fault_i,  // Escape entry error, per lane
    input  wire [3:0]    unknown_type_i,     // Unknown data type, per channel
    input  wire [3:0]    header_fixed_i,     // Header corrected by ECC, per channel
    input  wire          line_order_ev_i,    // Line sequence fault pulse
    input  wire          line_pair_ev_i,     // Line start/end mismatch pulse
    input  wire [1:0]    line_vc_i,          // Channel of the line fault
    input  wire [5:0]    line_dt_i,          // Data type of the line fault
    output wire          err_any_o,          // Some unmasked flag is set
    output wire          irq_o               // Interrupt, level, active high
);

    localparam W1 = `CSIERR_ERR1_W;
    localparam W2 = `CSIERR_ERR2_W;

    // Full-word reset constants, cut to each register's implemented width
    localparam [31:0] MASK_RST = `CSIERR_MASK_RST;
    localparam [31:0] IEN_RST  = `CSIERR_IEN_RST;

    // Address decode shared by the read and write paths
    function hit;
        input [AW-1:0] addr;
        input [AW-1:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // Compare a line fault's identifier with one programmed select byte
    function id_match;
        input [7:0] sel;
        input [1:0] vc;
        input [5:0] dt;
        begin
            id_match = (sel[`CSIERR_ID_VC_MSB:`CSIERR_ID_VC_LSB] == vc) &&
                       (sel[`CSIERR_ID_DT_MSB:`CSIERR_ID_DT_LSB] == dt);
        end
    endfunction

    reg  [W1-1:0] mask1_q;
    reg  [W1-1:0] mask1_d;
    reg  [W2-1:0] mask2_q;
    reg  [W2-1:0] mask2_d;
    reg  [W1-1:0] ien1_q;
    reg  [W1-1:0] ien1_d;
    reg  [W2-1:0] ien2_q;
    reg  [W2-1:0] ien2_d;
    reg  [31:0]   idsel1_q;
    reg  [31:0]   idsel1_d;
    reg  [31:0]   idsel2_q;
    reg  [31:0]   idsel2_d;
    reg  [31:0]   rdata_q;
    reg  [31:0]   rdata_d;
    reg           err_any_q;
    reg           err_any_d;
    reg           irq_q;
    reg           irq_d;

    reg  [7:0]    id_hit;
    reg  [W1-1:0] set1;
    reg  [W2-1:0] set2;
    reg  [W1-1:0] clr1;
    reg  [W2-1:0] clr2;
    reg  [W1-1:0] live1;
    reg  [W2-1:0] live2;
    integer       i;

    wire [W1-1:0] err1;
    wire [W2-1:0] err2;
    wire [63:0]   idsel_all;

    assign idsel_all = {idsel2_q, idsel1_q};

    // Identifier select: bytes 0..3 of first, 0..3 of second hold ids 0..7
    always @* begin
        id_hit = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            id_hit[i] = id_match(idsel_all[i*8 +: 8], line_vc_i, line_dt_i);
        end
    end

    // First error layout assembly
    always @* begin
        set1 = {W1{1'b0}};
        set1[`CSIERR_E1_ECC_DBL] = ecc_double_i;
        set1[`CSIERR_E1_CKSUM_LSB +: 4] = checksum_fault_i;
        set1[`CSIERR_E1_LORD_LSB +: 4] = id_hit[3:0] & {4{line_order_ev_i}};
        set1[`CSIERR_E1_LPAIR_LSB +: 4] = id_hit[3:0] & {4{line_pair_ev_i}};
        set1[`CSIERR_E1_FCRC_LSB +: 4] = frame_crc_fault_i;
        set1[`CSIERR_E1_FORD_LSB +: 4] = frame_order_fault_i;
        set1[`CSIERR_E1_FPAIR_LSB +: 4] = frame_pair_fault_i;
        set1[`CSIERR_E1_SOTNS_LSB +: 4] = sot_nosync_i;
    end

    // Second error layout assembly; bit n of each group is channel or lane n, or id n+4 in the line groups
    always @* begin
        set2 = {W2{1'b0}};
        set2[`CSIERR_E2_LORD_LSB +: 4] = id_hit[7:4] & {4{line_order_ev_i}};
        set2[`CSIERR_E2_LPAIR_LSB +: 4] = id_hit[7:4] & {4{line_pair_ev_i}};
        set2[`CSIERR_E2_UNKT_LSB +: 4] = unknown_type_i;
        set2[`CSIERR_E2_HFIX_LSB +: 4] = header_fixed_i;
        set2[`CSIERR_E2_SOTS_LSB +: 4] = sot_sync_i;
        set2[`CSIERR_E2_ESC_LSB +: 4] = esc_entry_fault_i;
    end

    // Write-one-to-clear registers; nothing is stored for them
    always @* begin
        clr1 = {W1{1'b0}};
        clr2 = {W2{1'b0}};
        if (reg_wr_i && hit(reg_addr_i, `CSIERR_OFF_CLR1)) begin
            clr1 = reg_wdata_i[W1-1:0];
        end
        if (reg_wr_i && hit(reg_addr_i, `CSIERR_OFF_CLR2)) begin
            clr2 = reg_wdata_i[W2-1:0];
        end
    end

    csierr_flags #(
        .W (W1)
    ) u_err1 (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .set_i     (set1),
        .clr_i     (clr1),
        .flags_o   (err1)
    );

    csierr_flags #(
        .W (W2)
    ) u_err2 (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .set_i     (set2),
        .clr_i     (clr2),
        .flags_o   (err2)
    );

    // Writable registers; only implemented bits are kept
    always @* begin
        mask1_d  = mask1_q;
        mask2_d  = mask2_q;
        ien1_d   = ien1_q;
        ien2_d   = ien2_q;
        idsel1_d = idsel1_q;
        idsel2_d = idsel2_q;
        if (reg_wr_i) begin
            if (hit(reg_addr_i, `CSIERR_OFF_MASK1)) begin
                mask1_d = reg_wdata_i[W1-1:0];
            end
            if (hit(reg_addr_i, `CSIERR_OFF_MASK2)) begin
                mask2_d = reg_wdata_i[W2-1:0];
            end
            if (hit(reg_addr_i, `CSIERR_OFF_IEN1)) begin
                ien1_d = reg_wdata_i[W1-1:0];
            end
            if (hit(reg_addr_i, `CSIERR_OFF_IEN2)) begin
                ien2_d = reg_wdata_i[W2-1:0];
            end
            if (hit(reg_addr_i, `CSIERR_OFF_IDSEL1)) begin
                idsel1_d = reg_wdata_i;
            end
            if (hit(reg_addr_i, `CSIERR_OFF_IDSEL2)) begin
                idsel2_d = reg_wdata_i;
            end
        end
    end

    // Read mux; clear registers and unmapped addresses read zero
    always @* begin
        rdata_d = `CSIERR_RDATA_RST;
        if (reg_rd_i) begin
            if (hit(reg_addr_i, `CSIERR_OFF_ERR1)) begin
                rdata_d[W1-1:0] = err1;
            end else if (hit(reg_addr_i, `CSIERR_OFF_ERR2)) begin
                rdata_d[W2-1:0] = err2;
            end else if (hit(reg_addr_i, `CSIERR_OFF_MASK1)) begin
                rdata_d[W1-1:0] = mask1_q;
            end else if (hit(reg_addr_i, `CSIERR_OFF_MASK2)) begin
                rdata_d[W2-1:0] = mask2_q;
            end else if (hit(reg_addr_i, `CSIERR_OFF_IEN1)) begin
                rdata_d[W1-1:0] = ien1_q;
            end else if (hit(reg_addr_i, `CSIERR_OFF_IEN2)) begin
                rdata_d[W2-1:0] = ien2_q;
            end else if (hit(reg_addr_i, `CSIERR_OFF_IDSEL1)) begin
                rdata_d = idsel1_q;
            end else if (hit(reg_addr_i, `CSIERR_OFF_IDSEL2)) begin
                rdata_d = idsel2_q;
            end
        end
    end

    // Mask removes a flag from both the combined error and the interrupt
    always @* begin
        live1     = err1 & ~mask1_q;
        live2     = err2 & ~mask2_q;
        err_any_d = (|live1) | (|live2);
        irq_d     = (|(live1 & ien1_q)) | (|(live2 & ien2_q));
    end

    always @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            mask1_q   <= MASK_RST[W1-1:0];
            mask2_q   <= MASK_RST[W2-1:0];
            ien1_q    <= IEN_RST[W1-1:0];
            ien2_q    <= IEN_RST[W2-1:0];
            idsel1_q  <= `CSIERR_IDSEL_RST;
            idsel2_q  <= `CSIERR_IDSEL_RST;
            rdata_q   <= `CSIERR_RDATA_RST;
            err_any_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            mask1_q   <= mask1_d;
            mask2_q   <= mask2_d;
            ien1_q    <= ien1_d;
            ien2_q    <= ien2_d;
            idsel1_q  <= idsel1_d;
            idsel2_q  <= idsel2_d;
            rdata_q   <= rdata_d;
            err_any_q <= err_any_d;
            irq_q     <= irq_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign err_any_o   = err_any_q;
    assign irq_o       = irq_q;

endmodule
`default_nettype wire

/* bench/csierr_chk.sv */
// Assertion checker for the error status and mask bank.
// Assumes a bind onto csierr_top; sees only that module's ports.
`default_nettype none
module csierr_chk (
    input wire logic        clk_sys_i,         // Clock
    input wire logic        nrst_i,            // Reset, active low
    input wire logic [7:0]  reg_addr_i,        // Address
    input wire logic        reg_wr_i,          // Write strobe
    input wire logic        reg_rd_i,          // Read strobe
    input wire logic [31:0] reg_rdata_o,       // Read data
    input wire logic [3:0]  unknown_type_i,    // Unknown type events
    input wire logic [3:0]  esc_entry_fault_i, // Escape entry events
    input wire logic        err_any_o,         // Combined error
    input wire logic        irq_o              // Interrupt
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    property p_rd_idle;
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h00000000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");
    property p_err2_top;
        $past(reg_rd_i) && $past(reg_addr_i) == 8'h04 |-> reg_rdata_o[31:24] == 8'h00;
    endproperty
    a_err2_top: assert property (p_err2_top)
        else $error("unused error bits read set");
    property p_mask1_top;
        $past(reg_rd_i) && $past(reg_addr_i) == 8'h08 |-> reg_rdata_o[31:29] == 3'h0;
    endproperty
    a_mask1_top: assert property (p_mask1_top)
        else $error("unused first mask bits read set");
    property p_mask2_top;
        $past(reg_rd_i) && $past(reg_addr_i) == 8'h0C |-> reg_rdata_o[31:24] == 8'h00;
    endproperty
    a_mask2_top: assert property (p_mask2_top)
        else $error("unused second mask bits read set");
    // Middle cycle excludes a clear write racing the read
    property p_unk_set;
        unknown_type_i != 4'h0 ##1 !reg_wr_i ##1 (reg_rd_i && reg_addr_i == 8'h04) |=>
            (reg_rdata_o[15:12] & $past(unknown_type_i, 3)) == $past(unknown_type_i, 3);
    endproperty
    a_unk_set: assert property (p_unk_set)
        else $error("unknown type flag missing");
    property p_esc_set;
        esc_entry_fault_i != 4'h0 ##1 !reg_wr_i ##1 (reg_rd_i && reg_addr_i == 8'h04) |=>
            (reg_rdata_o[3:0] & $past(esc_entry_fault_i, 3)) == $past(esc_entry_fault_i, 3);
    endproperty
    a_esc_set: assert property (p_esc_set)
        else $error("escape entry flag missing");
    property p_irq_sub;
        irq_o |-> err_any_o;
    endproperty
    a_irq_sub: assert property (p_irq_sub)
        else $error("interrupt without unmasked error");
    property p_sticky;
        err_any_o && !$past(reg_wr_i) |=> err_any_o;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("combined error dropped without a write");
endmodule
`default_nettype wire

/* bench/csierr_src.sv */
// Front-end stand-in raising link error events as one-cycle pulses.
// Assumes its tasks are called from a single bench process.
`default_nettype none
module csierr_src (
    input  wire logic       clk_sys_i,    // Clock
    output var logic [9:0][3:0] ev_o,     // Event groups
    output var logic        line_order_o, // Line order event
    output var logic        line_pair_o,  // Line pairing event
    output var logic [1:0]  line_vc_o,    // Line fault channel
    output var logic [5:0]  line_dt_o     // Line fault type
);
    initial begin
        ev_o = '0;
        line_order_o = 1'b0;
        line_pair_o = 1'b0;
        line_vc_o = 2'h0;
        line_dt_o = 6'h00;
    end
    task automatic pulse(input int g, input logic [3:0] v);
        @(posedge clk_sys_i);
        ev_o[g] <= v;
        @(posedge clk_sys_i);
        ev_o[g] <= 4'h0;
    endtask
    task automatic line(input logic pair, input logic [1:0] vc, input logic [5:0] dt);
        @(posedge clk_sys_i);
        line_pair_o <= pair;
        line_order_o <= !pair;
        line_vc_o <= vc;
        line_dt_o <= dt;
        @(posedge clk_sys_i);
        line_pair_o <= 1'b0;
        line_order_o <= 1'b0;
        // Stale tag must not look valid
        line_vc_o <= ~vc;
        line_dt_o <= ~dt;
    endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the error status and mask bank.
// Assumes csierr_src drives events and csierr_chk is bound below.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic            clk_sys_i = 1'b0;
    logic            nrst_i = 1'b0;
    logic [7:0]      reg_addr_i = 8'h00;
    logic [31:0]     reg_wdata_i = 32'h00000000;
    logic            reg_wr_i = 1'b0;
    logic            reg_rd_i = 1'b0;
    logic [31:0]     reg_rdata_o;
    logic            err_any_o;
    logic            irq_o;
    logic [9:0][3:0] ev;
    logic            lo;
    logic            lp;
    logic [1:0]      lvc;
    logic [5:0]      ldt;
    logic [31:0]     e1 = 32'h00000000;
    logic [31:0]     e2 = 32'h00000000;
    int              bad_count = 0;
    int              samples_checked = 0;
    int              off [10] = '{12, 8, 4, 0, 24, 12, 8, 4, 0, 28};

    always #5 clk_sys_i = ~clk_sys_i;

    csierr_src src_u (.clk_sys_i, .ev_o(ev), .line_order_o(lo), .line_pair_o(lp),
                      .line_vc_o(lvc), .line_dt_o(ldt));
    csierr_top dut_u (
        .clk_sys_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .ecc_double_i(ev[9][0]), .checksum_fault_i(ev[4]), .frame_crc_fault_i(ev[5]),
        .frame_order_fault_i(ev[6]), .frame_pair_fault_i(ev[7]), .sot_nosync_i(ev[8]),
        .sot_sync_i(ev[2]), .esc_entry_fault_i(ev[3]), .unknown_type_i(ev[0]),
        .header_fixed_i(ev[1]), .line_order_ev_i(lo), .line_pair_ev_i(lp),
        .line_vc_i(lvc), .line_dt_i(ldt), .err_any_o, .irq_o);

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, exp);
    endtask
    // Outputs are registered after the flags and masks
    task automatic wait_out;
        @(posedge clk_sys_i);
        #1;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rd(8'h04, 32'h00000000);
        rd(8'h08, 32'h00000000);
        rd(8'h0C, 32'h00000000);
        for (int g = 0; g < 10; g++) begin
            src_u.pulse(g, 4'hB);
            if (g < 4)
                e2 = e2 | (32'hB << off[g]);
            else if (g < 9)
                e1 = e1 | (32'hB << off[g]);
            else
                e1 = e1 | 32'h10000000;
            rd(g < 4 ? 8'h04 : 8'h00, g < 4 ? e2 : e1);
        end
        wr(8'h14, 32'hD200006A);
        rd(8'h14, 32'hD200006A);
        src_u.line(1'b0, 2'h1, 6'h2A);
        src_u.line(1'b1, 2'h3, 6'h12);
        src_u.line(1'b0, 2'h0, 6'h00);
        e2 = e2 | 32'h00780000;
        e1 = e1 | 32'h00F00000;
        rd(8'h04, e2);
        rd(8'h00, e1);
        chk(32'(err_any_o), 32'h00000001);
        wr(8'h08, 32'hFFFFFFFF);
        wr(8'h0C, 32'hFFFFFFFF);
        wait_out;
        chk(32'(err_any_o), 32'h00000000);
        rd(8'h08, 32'h1FFFFFFF);
        rd(8'h0C, 32'h00FFFFFF);
        wr(8'h24, 32'h00001000);
        wr(8'h0C, 32'hFFFFEFFF);
        wait_out;
        chk(32'(irq_o), 32'h00000001);
        wr(8'h1C, 32'h00001000);
        wait_out;
        chk(32'(irq_o), 32'h00000000);
        chk(32'(err_any_o), 32'h00000000);
        rd(8'h04, e2 & 32'hFFFFEFFF);
        // First select bank: id1 on channel 3, type 05
        wr(8'h10, 32'h0000C500);
        rd(8'h10, 32'h0000C500);
        src_u.line(1'b1, 2'h3, 6'h05);
        e1 = e1 | 32'h00020000;
        rd(8'h00, e1);
        rd(8'h04, e2 & 32'hFFFFEFFF);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h1FFFFFFF);
        rd(8'h18, 32'h00000000);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h00000000);
        wr(8'h18, 32'hFFFFFFFF);
        wr(8'h1C, 32'hFFFFFFFF);
        rd(8'h00, 32'h00000000);
        rd(8'h04, 32'h00000000);
        final_report;
    end

    initial begin
        #100000;
        bad_count++;
        final_report;
    end
endmodule

bind csierr_top csierr_chk chk_u (.clk_sys_i, .nrst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .unknown_type_i, .esc_entry_fault_i, .err_any_o, .irq_o);
`default_nettype wire
